// [src/dotc_pkg.sv]
// package for the dram termination control block: field layouts, latency offsets, types
// assumes one command clock, mode register images supplied as plain ports
package dotc_pkg;
   localparam int DOTC_RTT_W     = 3;           // width of each termination code
   localparam int DOTC_LAT_W     = 6;           // width of latency counts
   localparam int DOTC_PIPE_D    = 64;          // depth of the odt sample history
   localparam int DOTC_NOM_HI    = 10;          // mr1 nominal field msb
   localparam int DOTC_NOM_LO    = 8;           // mr1 nominal field lsb
   localparam int DOTC_WR_HI     = 11;          // mr2 write field msb
   localparam int DOTC_WR_LO     = 9;           // mr2 write field lsb
   localparam int DOTC_DYN_B0    = 9;           // mr2 bit a9
   localparam int DOTC_DYN_B1    = 10;          // mr2 bit a10
   localparam int DOTC_PARK_HI   = 8;           // mr5 park field msb
   localparam int DOTC_PARK_LO   = 6;           // mr5 park field lsb
   localparam int DOTC_IBD_B     = 5;           // mr5 bit a5, odt buffer disable
   localparam logic [DOTC_LAT_W-1:0] DOTC_PRE1_SUB = 6'h02; // offset with 1 tck preamble
   localparam logic [DOTC_LAT_W-1:0] DOTC_PRE2_SUB = 6'h03; // offset with 2 tck preamble
   localparam logic [DOTC_LAT_W-1:0] DOTC_ANPD_SUB = 6'h01; // tanpd = wl - 1
   localparam logic [DOTC_LAT_W-1:0] DOTC_BC4_P1   = 6'h04; // bc4, 1 tck, crc off
   localparam logic [DOTC_LAT_W-1:0] DOTC_BC4_P1C  = 6'h05; // bc4, 1 tck, crc on (illegible, assumed)
   localparam logic [DOTC_LAT_W-1:0] DOTC_BC4_P2   = 6'h05; // bc4, 2 tck, crc off
   localparam logic [DOTC_LAT_W-1:0] DOTC_BC4_P2C  = 6'h08; // bc4, 2 tck, crc on
   localparam logic [DOTC_LAT_W-1:0] DOTC_BL8_P1   = 6'h06; // bl8, 1 tck, crc off
   localparam logic [DOTC_LAT_W-1:0] DOTC_BL8_P1C  = 6'h07; // bl8, 1 tck, crc on
   localparam logic [DOTC_LAT_W-1:0] DOTC_BL8_P2   = 6'h07; // bl8, 2 tck, crc off
   localparam logic [DOTC_LAT_W-1:0] DOTC_BL8_P2C  = 6'h08; // bl8, 2 tck, crc on
   localparam logic [DOTC_RTT_W-1:0] DOTC_RTT_OFF  = 3'h0;  // code for disabled/hi-z

   // latency configuration carried as one bundle
   typedef struct packed {
      logic [DOTC_LAT_W-1:0] cwl;               // cas write latency
      logic [DOTC_LAT_W-1:0] al;                // additive latency
      logic [DOTC_LAT_W-1:0] pl;                // parity latency
      logic                  pre2;              // 2 tck write preamble
      logic                  crc;               // write crc enabled
   } dotc_lat_t;

   // applied termination state
   typedef enum logic [1:0] {
      DOTC_ST_HIZ,
      DOTC_ST_PARK,
      DOTC_ST_NOM,
      DOTC_ST_WR
   } dotc_state_t;
endpackage

// [src/dotc_ctrl.sv]
// termination control core of the dram: dynamic write switching, direct odt, async and power-down modes
// assumes commands are already decoded to a one-cycle write strobe on i_clk; the odt pin is asynchronous
//
// How it works
// - dynamic switching when mr2 a9 or a10 set
// - values from mr1[10:8], mr2[11:9], mr5[8:6]
// - idle: nom follows delayed odt, else park
// - write selects rtt_wr after odtlcnw cycles
// - bc4 releases rtt_wr at cnw plus 4/5/8
// - bl8 releases rtt_wr at cnw plus 6/7/8
// - burst length per write, fixed or otf
// - no dynamic switching while dll off
// - dll off: odt not delayed by latency
// - async: park to nom on odt high
// - async: nom to park on odt low
// - buffer disable: no nom in power-down
// - nom drops only once cke is low, not tanpd before entry
// - priority off, wr, nom, park
// - dodtl = cwl+al+pl minus 2 or 3
`timescale 1ns/10ps
module dotc_ctrl
   import dotc_pkg::*;
(
   input  wire logic                  i_clk,       // 125 MHz command clock
   input  wire logic                  i_sys_rst,   // synchronous, active high
   input  wire logic                  i_odt,       // odt pin, asynchronous to logic
   input  wire logic                  i_cke_reg,   // cke as registered by the command decoder
   input  wire logic                  i_wr_cmd,    // one-cycle strobe: any write registered
   input  wire logic                  i_wr_bc4,    // burst chop 4 in force for this write
   input  wire logic                  i_dll_off,   // dll off mode
   input  wire logic                  i_self_ref,  // self refresh: termination off
   input  wire logic [13:0]           i_mr1,       // mode register 1 image
   input  wire logic [13:0]           i_mr2,       // mode register 2 image
   input  wire logic [13:0]           i_mr5,       // mode register 5 image
   input  wire dotc_lat_t             i_lat,       // latency and preamble settings
   output logic      [DOTC_RTT_W-1:0] o_rtt_code,  // applied termination value
   output dotc_state_t                o_rtt_state, // applied termination state
   output logic                       o_dyn_en     // dynamic switching active
);
   logic [2:0]                  odt_sync_r;    // three-stage pin synchroniser
   logic                        odt_q_r;       // filtered odt level
   logic [DOTC_PIPE_D-1:0]      odt_hist_r;    // odt history, bit 0 newest
   logic [DOTC_PIPE_D-1:0]      pd_hist_r;     // power-down history, bit 0 newest
   logic [DOTC_PIPE_D-1:0]      wr_on_r;       // write strobe history
   logic [DOTC_PIPE_D-1:0]      wr_off4_r;     // bc4 write strobe history
   logic [DOTC_PIPE_D-1:0]      wr_off8_r;     // bl8 write strobe history
   logic                        wr_act_r;      // rtt_wr window open
   logic                        pd_r;          // in power-down
   logic [DOTC_LAT_W-1:0]       wl;            // write latency
   logic [DOTC_LAT_W-1:0]       cnw;           // odtlcnw
   logic [DOTC_LAT_W-1:0]       off4;          // bc4 release latency
   logic [DOTC_LAT_W-1:0]       off8;          // bl8 release latency
   logic [DOTC_LAT_W-1:0]       anpd;          // tanpd
   logic [DOTC_RTT_W-1:0]       nom_val;       // mr1 nominal value
   logic [DOTC_RTT_W-1:0]       wr_val;        // mr2 write value
   logic [DOTC_RTT_W-1:0]       park_val;      // mr5 park value
   logic                        ibd_en;        // buffer disable option
   logic                        odt_eff;       // odt after latency or direct
   logic                        nom_blk;       // nominal blocked by power-down
   logic                        on_hit;        // write reaches odtlcnw
   logic                        off_hit;       // write reaches release point
   dotc_state_t                 st_nxt;        // next applied state
   logic [DOTC_RTT_W-1:0]       code_nxt;      // next applied value

   // tap a history vector at a latency; index 0 means the current cycle
   // bit k of a history holds the sample taken k+1 edges ago, so a tap at n
   // reads the event that happened n edges before the edge that uses it;
   // latencies of 64 or more would wrap, which the mode register ranges never reach
   function automatic logic dotc_tap(input logic [DOTC_PIPE_D-1:0] h, input logic [DOTC_LAT_W-1:0] n,
                                      input logic now);
      dotc_tap = (n == '0) ? now : h[n - 6'h01];
   endfunction

   // saturating subtract keeps short latency settings from wrapping
   function automatic logic [DOTC_LAT_W-1:0] dotc_sub(input logic [DOTC_LAT_W-1:0] a,
                                                       input logic [DOTC_LAT_W-1:0] b);
      dotc_sub = (a > b) ? a - b : '0;
   endfunction

   // field extraction and latency arithmetic
   always_comb begin
      nom_val  = i_mr1[DOTC_NOM_HI:DOTC_NOM_LO];
      wr_val   = i_mr2[DOTC_WR_HI:DOTC_WR_LO];
      park_val = i_mr5[DOTC_PARK_HI:DOTC_PARK_LO];
      ibd_en   = i_mr5[DOTC_IBD_B];
      // writes switch only with dll on and a9/a10 set; mr2 000 turns it off
      o_dyn_en = (i_mr2[DOTC_DYN_B0] | i_mr2[DOTC_DYN_B1]) & ~i_dll_off;
      wl       = DOTC_LAT_W'(i_lat.cwl + i_lat.al + i_lat.pl);
      cnw      = dotc_sub(wl, i_lat.pre2 ? DOTC_PRE2_SUB : DOTC_PRE1_SUB);
      anpd     = dotc_sub(wl, DOTC_ANPD_SUB);
      // release offsets from the preamble and crc matrix
      case ({i_lat.pre2, i_lat.crc})
         2'h0:    begin off4 = DOTC_BC4_P1;  off8 = DOTC_BL8_P1;  end
         2'h1:    begin off4 = DOTC_BC4_P1C; off8 = DOTC_BL8_P1C; end
         2'h2:    begin off4 = DOTC_BC4_P2;  off8 = DOTC_BL8_P2;  end
         default: begin off4 = DOTC_BC4_P2C; off8 = DOTC_BL8_P2C; end
      endcase
      off4 = DOTC_LAT_W'(cnw + off4);
      off8 = DOTC_LAT_W'(cnw + off8);
   end

   // pin synchroniser; a change counts once stages two and three agree
   // the pin has no relation to i_clk, so only the second stage feeds the
   // third and the filter; the cost is three to four cycles of extra delay,
   // which is far below the latency budget of the direct odt path
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         odt_sync_r <= 3'h0;
         odt_q_r    <= 1'b0;
      end else begin
         odt_sync_r <= {odt_sync_r[1:0], i_odt};
         if (odt_sync_r[1] == odt_sync_r[2]) begin
            odt_q_r <= odt_sync_r[2];
         end
      end
   end

   // odt and power-down histories feed the direct latency taps
   // both histories shift every cycle, even in dll off mode, so that a change
   // back to synchronous mode finds them filled with real samples
   // the power-down history is tapped at cnw minus tanpd, which saturates to
   // zero, so nominal is withdrawn only while cke is low, whenever its odt sample was taken
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         odt_hist_r <= '0;
         pd_hist_r  <= '0;
         pd_r       <= 1'b0;
      end else begin
         odt_hist_r <= {odt_hist_r[DOTC_PIPE_D-2:0], odt_q_r};
         pd_hist_r  <= {pd_hist_r[DOTC_PIPE_D-2:0], ~i_cke_reg};
         pd_r       <= ~i_cke_reg;
      end
   end

   // write strobes split by the burst length in force for each write
   // the burst kind is latched with the strobe, so a later on-the-fly change
   // cannot move the release point of a write already in flight
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         wr_on_r   <= '0;
         wr_off4_r <= '0;
         wr_off8_r <= '0;
      end else begin
         wr_on_r   <= {wr_on_r[DOTC_PIPE_D-2:0], i_wr_cmd & o_dyn_en};
         wr_off4_r <= {wr_off4_r[DOTC_PIPE_D-2:0], i_wr_cmd & o_dyn_en & i_wr_bc4};
         wr_off8_r <= {wr_off8_r[DOTC_PIPE_D-2:0], i_wr_cmd & o_dyn_en & ~i_wr_bc4};
      end
   end

   // window open/close; a later write's turn-on wins over an earlier release
   // a turn-on in the cycle of an earlier write's release therefore keeps rtt_wr on without a one-cycle gap;
   // any release without a turn-on in the same cycle closes the window, even while a later write is in flight
   always_comb begin
      on_hit  = dotc_tap(wr_on_r, cnw, i_wr_cmd & o_dyn_en);
      off_hit = dotc_tap(wr_off4_r, off4, i_wr_cmd & o_dyn_en & i_wr_bc4)
              | dotc_tap(wr_off8_r, off8, i_wr_cmd & o_dyn_en & ~i_wr_bc4);
   end

   // rtt_wr window register, dropped at once if dynamic mode goes away
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         wr_act_r <= 1'b0;
      end else if (!o_dyn_en) begin
         wr_act_r <= 1'b0;
      end else if (on_hit) begin
         wr_act_r <= 1'b1;
      end else if (off_hit) begin
         wr_act_r <= 1'b0;
      end
   end

   // direct odt path: latency taps in sync mode, straight level when dll is off
   // in dll off mode the filtered level is used as is: no additive or parity
   // latency applies there, and the output register adds the one edge of
   // response time counted from the sampling edge
   always_comb begin
      if (i_dll_off) begin
         odt_eff = odt_q_r;
         nom_blk = ibd_en & pd_r;
      end else begin
         odt_eff = dotc_tap(odt_hist_r, cnw, odt_q_r);
         // cnw minus tanpd saturates to zero, so the tap reads pd_r: only a current power-down blocks
         nom_blk = ibd_en & (pd_r | dotc_tap(pd_hist_r, dotc_sub(cnw, anpd), pd_r));
      end
   end

   // priority resolution of the applied termination
   // self refresh switches everything off; then rtt_wr, then nominal, then park
   // a zero code in a field means that level is disabled, so resolution falls
   // through to the next level rather than applying a disabled value
   always_comb begin
      if (i_self_ref) begin
         st_nxt   = DOTC_ST_HIZ;
         code_nxt = DOTC_RTT_OFF;
      end else if (wr_act_r && wr_val != DOTC_RTT_OFF) begin
         st_nxt   = DOTC_ST_WR;
         code_nxt = wr_val;
      end else if (odt_eff && !nom_blk && nom_val != DOTC_RTT_OFF) begin
         st_nxt   = DOTC_ST_NOM;
         code_nxt = nom_val;
      end else if (park_val != DOTC_RTT_OFF) begin
         st_nxt   = DOTC_ST_PARK;
         code_nxt = park_val;
      end else begin
         st_nxt   = DOTC_ST_HIZ;
         code_nxt = DOTC_RTT_OFF;
      end
   end

   // registered outputs
   // both outputs come from flip-flops so that the termination switch sees a
   // glitch-free code; this costs one edge on every latency, already counted
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_rtt_state <= DOTC_ST_HIZ;
         o_rtt_code  <= DOTC_RTT_OFF;
      end else begin
         o_rtt_state <= st_nxt;
         o_rtt_code  <= code_nxt;
      end
   end

   // checks
   // timing seen by the properties: an event sampled at edge e sets the window
   // register at e, and the output register shows the result at e+1, so a
   // property on the window state looks one edge later and one on the output
   // state looks two edges later
   // the code checks compare against the field value of the previous cycle,
   // since the code register took its value then
   a_wr_needs_dyn: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (o_rtt_state == DOTC_ST_WR) |-> $past(o_dyn_en) || $past(wr_act_r))
      else $error("rtt_wr without dynamic mode");
   a_dyn_enable: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      o_dyn_en == ((i_mr2[DOTC_DYN_B0] | i_mr2[DOTC_DYN_B1]) & ~i_dll_off))
      else $error("dynamic enable mismatch");
   a_wr_value: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (o_rtt_state == DOTC_ST_WR) |-> (o_rtt_code == $past(wr_val)))
      else $error("rtt_wr code wrong");
   a_wr_on_time: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (on_hit && o_dyn_en && !i_self_ref && wr_val != DOTC_RTT_OFF) |=> ##1 (o_rtt_state == DOTC_ST_WR))
      else $error("rtt_wr not selected at odtlcnw");
   a_wr_off_time: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (off_hit && !on_hit && o_dyn_en) |=> !wr_act_r)
      else $error("rtt_wr not released");
   a_wr_priority: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (wr_act_r && !i_self_ref && wr_val != DOTC_RTT_OFF) |=> (o_rtt_state == DOTC_ST_WR))
      else $error("rtt_wr lost priority");
   a_pd_no_nom: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (ibd_en && pd_r && $stable(ibd_en)) |=> (o_rtt_state != DOTC_ST_NOM))
      else $error("rtt_nom in power-down");
   a_async_on: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_dll_off && odt_q_r && !nom_blk && !i_self_ref && !wr_act_r && nom_val != DOTC_RTT_OFF)
      |=> (o_rtt_state == DOTC_ST_NOM))
      else $error("async turn-on missed");
   a_async_off: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (i_dll_off && !odt_q_r && !i_self_ref && !wr_act_r && park_val != DOTC_RTT_OFF)
      |=> (o_rtt_state == DOTC_ST_PARK))
      else $error("async turn-off missed");

   // self refresh overrides every other source of termination
   a_selfref_hiz: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      i_self_ref |=> (o_rtt_state == DOTC_ST_HIZ && o_rtt_code == DOTC_RTT_OFF))
      else $error("termination on in self refresh");

   // park and nominal states carry their own field values
   a_park_code: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (o_rtt_state == DOTC_ST_PARK) |-> (o_rtt_code == $past(park_val)))
      else $error("rtt_park code wrong");
   a_nom_code: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (o_rtt_state == DOTC_ST_NOM) |-> (o_rtt_code == $past(nom_val)))
      else $error("rtt_nom code wrong");

   // nominal only follows a high effective odt level
   a_nom_needs_odt: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (o_rtt_state == DOTC_ST_NOM) |-> $past(odt_eff))
      else $error("rtt_nom without odt");

   // dll off closes any write window at the next edge
   a_dll_off_no_wr: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      i_dll_off |=> !wr_act_r)
      else $error("write window open with dll off");

   c_write_window: cover property (@(posedge i_clk) disable iff (i_sys_rst)
      (o_rtt_state == DOTC_ST_WR) ##1 (o_rtt_state != DOTC_ST_WR));
   c_nom_on: cover property (@(posedge i_clk) disable iff (i_sys_rst) o_rtt_state == DOTC_ST_NOM);
   c_async_nom: cover property (@(posedge i_clk) disable iff (i_sys_rst)
      i_dll_off && o_rtt_state == DOTC_ST_NOM);
   c_pd_block: cover property (@(posedge i_clk) disable iff (i_sys_rst) nom_blk && odt_eff);
   // a write window opened while nominal was applied
   c_wr_over_nom: cover property (@(posedge i_clk) disable iff (i_sys_rst)
      (o_rtt_state == DOTC_ST_NOM) ##1 (o_rtt_state == DOTC_ST_WR));
endmodule // dotc_ctrl

// [test/dotc_host_model.sv]
// controller-side model: drives odt, cke and write strobes toward the termination block
// assumes each task is entered just after a rising edge of i_clk
`timescale 1ns/10ps
module dotc_host_model (
   input  wire logic i_clk, // command clock
   output logic      o_odt, // odt pin level
   output logic      o_cke, // registered cke level
   output logic      o_wr,  // one-cycle write strobe
   output logic      o_bc4  // burst chop qualifier of the write
);
   // idle controller: no write, odt low, cke high
   initial begin
      o_odt = 1'b0;
      o_cke = 1'b1;
      o_wr  = 1'b0;
      o_bc4 = 1'b0;
   end
   // strobe lasts one cycle; qualifier is set with it and left, the block ignores it otherwise
   task automatic write(input logic bc4);
      o_wr  <= 1'b1;
      o_bc4 <= bc4;
      @(posedge i_clk);
      o_wr  <= 1'b0;
   endtask
   // plain odt level change
   task automatic set_odt(input logic v);
      o_odt <= v;
   endtask
   // entry touches cke only, so odt stays steady across the entry
   task automatic pd_enter();
      o_cke <= 1'b0;
   endtask
   // exit drives odt low with cke high and holds it for txp cycles
   task automatic pd_exit(input int txp);
      o_odt <= 1'b0;
      o_cke <= 1'b1;
      repeat (txp) @(posedge i_clk);
   endtask
endmodule // dotc_host_model

// [test/dotc_ctrl_tb_top.sv]
// self-checking bench for the termination control core
// assumes dotc_pkg is compiled first and the host model plays the memory controller
`timescale 1ns/10ps
module dotc_ctrl_tb_top;
   import dotc_pkg::*;
   // one expected result, judged at the falling edge of the given cycle
   typedef struct {
      int          cyc;  // cycle count to judge at
      dotc_state_t st;   // expected state
      logic [2:0]  code; // expected termination code
   } dotc_note_t;
   logic        clk      = 1'b0;    // command clock
   logic        rst      = 1'b1;    // synchronous reset
   logic        dll_off  = 1'b0;    // dll off mode
   logic        self_ref = 1'b0;    // self refresh
   logic [13:0] mr1      = 14'h0000; // mode register images
   logic [13:0] mr2      = 14'h0000;
   logic [13:0] mr5      = 14'h0000;
   dotc_lat_t   lat      = '0;      // latency settings
   logic        odt, cke, wr, bc4;  // driven by the controller model
   logic [2:0]  code;               // observed code
   dotc_state_t st;                 // observed state
   logic        dyn;                // observed dynamic enable
   logic [2:0]  nom_v, wr_v, park_v; // field values in force
   int          cyc = 0, err_total = 0, n_tests = 0, seed = 31, cnw;
   int          t4[4] = '{4, 5, 5, 8}; // bc4 release offsets by {pre2, crc}
   int          t8[4] = '{6, 7, 7, 8}; // bl8 release offsets by {pre2, crc}
   dotc_note_t  q[$];               // expected results, oldest first

   dotc_host_model dotc_host_model_i (.i_clk(clk), .o_odt(odt), .o_cke(cke), .o_wr(wr), .o_bc4(bc4));
   dotc_ctrl dotc_ctrl_i (
      .i_clk       (clk),
      .i_sys_rst   (rst),
      .i_odt       (odt),
      .i_cke_reg   (cke),
      .i_wr_cmd    (wr),
      .i_wr_bc4    (bc4),
      .i_dll_off   (dll_off),
      .i_self_ref  (self_ref),
      .i_mr1       (mr1),
      .i_mr2       (mr2),
      .i_mr5       (mr5),
      .i_lat       (lat),
      .o_rtt_code  (code),
      .o_rtt_state (st),
      .o_dyn_en    (dyn)
   );

   // 125 MHz clock
   initial forever #4 clk = ~clk;
   task automatic end_sim();
      err_total += q.size(); // unjudged notes count as misses
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // cycle count, and a ceiling far above the expected run length
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         end_sim();
      end
   end
   task automatic check(input string what, input logic [3:0] seen, input logic [3:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // code follows from the state and the fields the bench programmed
   task automatic note(input int c, input dotc_state_t s);
      dotc_note_t n;
      n.cyc  = c;
      n.st   = s;
      n.code = (s == DOTC_ST_WR) ? wr_v : (s == DOTC_ST_NOM) ? nom_v : (s == DOTC_ST_PARK) ? park_v : 3'h0;
      q.push_back(n);
   endtask
   // monitor: falling edge, when registered outputs are settled
   always @(negedge clk) begin
      while (q.size() > 0 && q[0].cyc <= cyc) begin
         check("state", 4'(st), 4'(q[0].st));
         check("code", 4'(code), 4'(q[0].code));
         void'(q.pop_front());
      end
   end
   // latency bundle with given cwl and random pl; cnw follows from wl and preamble
   task automatic set_lat(input int k, input int cwl_v);
      int p;
      p = $unsigned($random(seed)) % 3;
      @(posedge clk);
      lat <= '{cwl: 6'(cwl_v), al: 6'h00, pl: 6'(p), pre2: k[1], crc: k[0]};
      cnw = cwl_v + p - (k[1] ? 3 : 2);
      repeat (3) @(posedge clk);
   endtask
   // write: edge before and at turn-on, edge before and at release
   task automatic do_wr(input logic b, input dotc_state_t idle, input dotc_state_t ws);
      int c;
      int off;
      @(posedge clk);
      c   = cyc;
      off = cnw + (b ? t4[{lat.pre2, lat.crc}] : t8[{lat.pre2, lat.crc}]);
      note(c + 2 + cnw, idle);
      note(c + 3 + cnw, ws);
      note(c + 2 + off, ws);
      note(c + 3 + off, idle);
      dotc_host_model_i.write(b);
      repeat (off + 6) @(posedge clk);
   endtask
   // odt step: old state just after, new state once the 3-4 cycle filter and latency passed
   task automatic odt_step(input logic v, input int lat_c);
      int c;
      @(posedge clk);
      c = cyc;
      note(c + 2 + lat_c, v ? DOTC_ST_PARK : DOTC_ST_NOM);
      note(c + 8 + lat_c, v ? DOTC_ST_NOM : DOTC_ST_PARK);
      dotc_host_model_i.set_odt(v);
      repeat (lat_c + 10) @(posedge clk);
   endtask

   initial begin
      repeat (5) @(posedge clk);
      rst    <= 1'b0;
      nom_v  = 3'($unsigned($random(seed)) % 7 + 1);
      park_v = 3'($unsigned($random(seed)) % 7 + 1);
      wr_v   = {1'($random(seed)), 2'($unsigned($random(seed)) % 3 + 1)};
      mr1    <= {3'h0, nom_v, 8'h00};
      mr2    <= {2'h0, wr_v, 9'h000};
      mr5    <= {5'h00, park_v, 6'h00};
      // every preamble/crc pairing with both burst kinds
      for (int k = 0; k < 4; k++) begin
         set_lat(k, 9 + $unsigned($random(seed)) % 12);
         check("dyn_en", 4'(dyn), 4'h1);
         do_wr(1'b1, DOTC_ST_PARK, DOTC_ST_WR);
         do_wr(1'b0, DOTC_ST_PARK, DOTC_ST_WR);
      end
      // direct odt, and a write overriding nominal
      set_lat(0, 11);
      odt_step(1'b1, cnw);
      do_wr(1'b0, DOTC_ST_NOM, DOTC_ST_WR);
      odt_step(1'b0, cnw);
      // write field all zero, then a9/a10 clear with a11 set: writes ignored
      for (int w = 0; w < 2; w++) begin
         wr_v = w ? 3'h4 : 3'h0;
         mr2  <= {2'h0, wr_v, 9'h000};
         @(posedge clk);
         check("dyn_en", 4'(dyn), 4'h0);
         do_wr(1'b0, DOTC_ST_PARK, DOTC_ST_PARK);
      end
      // dll off: no dynamic switching, odt unaffected by a long latency
      wr_v    = 3'h3;
      mr2     <= {2'h0, wr_v, 9'h000};
      dll_off <= 1'b1;
      set_lat(0, 20);
      check("dyn_en", 4'(dyn), 4'h0);
      do_wr(1'b1, DOTC_ST_PARK, DOTC_ST_PARK);
      odt_step(1'b1, 0);
      odt_step(1'b0, 0);
      // self refresh forces termination off
      self_ref <= 1'b1;
      note(cyc + 4, DOTC_ST_HIZ);
      repeat (6) @(posedge clk);
      self_ref <= 1'b0;
      // power-down with odt buffer disabled: nominal withdrawn although odt stays high
      dll_off  <= 1'b0;
      mr5      <= {5'h00, park_v, 1'b1, 5'h00};
      set_lat(0, 9);
      odt_step(1'b1, cnw);
      note(cyc + 4, DOTC_ST_PARK);
      dotc_host_model_i.pd_enter();
      repeat (8) @(posedge clk);
      dotc_host_model_i.pd_exit(5);
      repeat (cnw + 10) @(posedge clk);
      end_sim();
   end
endmodule // dotc_ctrl_tb_top
